// *** design/arc_pkg.sv ***
// Overview of operation
// - mode field picks basic, accumulate, average, burst average or low-pass filter.
// - basic mode: single or paired samples, done flag each conversion, accumulator untouched.
// - accumulate mode adds each result, counts it, raises done flag each conversion.
// - sample counter increments by one but saturates at its maximum value.
// - average mode accumulates; threshold test only once counter reaches repeat target.
// - average mode clears accumulator and counter on first trigger after completed test.
// - burst average clears at trigger, retriggers until counter reaches target, then tests.
// - low-pass mode filters every result; tests at target count and every later result.
// - clear bit clears accumulator, counter, overflow; hardware drops bit when done.
// - overflow flag set when accumulated value exceeds eighteen-bit maximum.
// - filtered result is accumulator right-shifted by shift count, ignoring justification.
package arc_pkg;
  localparam int ACC_W = 18;
  localparam int CNT_W = 8;
  localparam int RES_W = 12;
  localparam int CON_W = 13;
  localparam int SH_W = 3;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
  localparam logic [ACC_W-1:0] ACC_MAX = 18'h3ffff;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RPT = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0c;
  localparam logic [7:0] OFS_FLTR = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DOUBLE_SAMPLE_ENABLE_BIT = 3;
  localparam int CTRL_SHIFT_LSB = 4;
  localparam int CTRL_CLR_BIT = 8;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_THR_BIT = 1;
  localparam int STAT_OVF_BIT = 2;
  localparam int STAT_W = 3;

  localparam logic RST_DOUBLE_SAMPLE_ENABLE = 1'b0;
  localparam logic [SH_W-1:0] RST_SHIFT = 3'h0;
  localparam logic [CNT_W-1:0] RST_RPT = 8'h00;
  localparam logic [STAT_W-1:0] RST_STAT = 3'h0;
  localparam logic [STAT_W-1:0] RST_MASK = 3'h0;

  typedef enum logic [2:0] {
    MODE_BASIC = 3'b000,
    MODE_ACCUM = 3'b001,
    MODE_AVG = 3'b010,
    MODE_BURST = 3'b011,
    MODE_LPF = 3'b100
  } arc_mode_t;

  function automatic logic [ACC_W-1:0] arc_shr(input logic [ACC_W-1:0] v,
                                               input logic [SH_W-1:0] sh);
    arc_shr = v >> sh;
  endfunction : arc_shr
endpackage : arc_pkg

// *** design/arc_acc_if.sv ***
`timescale 1ns/10ps
interface arc_acc_if;
  import arc_pkg::*;
  arc_mode_t mode;
  logic [SH_W-1:0] shift;
  logic clr_req;
  logic clr_done;
  logic trig_clr;
  logic smp_vld;
  logic signed [CON_W-1:0] contrib;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] fltr;
  logic [CNT_W-1:0] cnt;
  logic ovf;
  logic upd;
  modport ctl (output mode, shift, clr_req, trig_clr, smp_vld, contrib,
               input clr_done, acc, fltr, cnt, ovf, upd);
  modport acu (input mode, shift, clr_req, trig_clr, smp_vld, contrib,
               output clr_done, acc, fltr, cnt, ovf, upd);
endinterface : arc_acc_if

// *** design/arc_accum.sv ***
`timescale 1ns/10ps
module arc_accum
  import arc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  arc_acc_if.acu a
);
  logic [ACC_W-1:0] acc_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic ovf_ff;
  logic upd_ff;
  logic clr_done_ff;
  logic signed [ACC_W+1:0] base;
  logic signed [ACC_W+1:0] sum;
  logic [CNT_W-1:0] cnt_base;

  always_comb
  begin
    base = a.trig_clr ? '0 : $signed({2'b00, acc_ff});
    if (a.mode == MODE_LPF && !a.trig_clr)
    begin
      base = base - $signed({2'b00, arc_shr(acc_ff, a.shift)});
    end
    sum = base + (ACC_W + 2)'(a.contrib);
    cnt_base = a.trig_clr ? '0 : cnt_ff;
  end

  always_ff @(posedge clk)
  begin
    if (reset || a.clr_req)
    begin
      acc_ff <= '0;
      cnt_ff <= '0;
      ovf_ff <= 1'b0;
    end
    else if (a.smp_vld)
    begin
      acc_ff <= sum[ACC_W-1:0];
      cnt_ff <= (cnt_base == CNT_MAX) ? cnt_base : cnt_base + 8'h01;
      if (sum > $signed({2'b00, ACC_MAX}))
      begin
        ovf_ff <= 1'b1;
      end
    end
    else if (a.trig_clr)
    begin
      acc_ff <= '0;
      cnt_ff <= '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      upd_ff <= 1'b0;
      clr_done_ff <= 1'b0;
    end
    else
    begin
      upd_ff <= a.smp_vld && !a.clr_req;
      clr_done_ff <= a.clr_req && !clr_done_ff;
    end
  end

  assign a.acc = acc_ff;
  assign a.fltr = arc_shr(acc_ff, a.shift);
  assign a.cnt = cnt_ff;
  assign a.ovf = ovf_ff;
  assign a.upd = upd_ff;
  assign a.clr_done = clr_done_ff;
endmodule : arc_accum

// *** design/arc_top.sv ***
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module arc_top
  import arc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_trig,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  output logic retrig,
  output logic test_strobe,
  output logic irq
);
  arc_acc_if acc_if ();

  arc_mode_t mode_ff;
  logic double_sample_enable_ff;
  logic [SH_W-1:0] shift_ff;
  logic clr_ff;
  logic [CNT_W-1:0] rpt_ff;
  logic [STAT_W-1:0] stat_ff;
  logic [STAT_W-1:0] mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic phase_ff;
  logic [RES_W-1:0] first_ff;
  logic basic_ff;
  logic test_ff;
  logic retrig_ff;
  logic irq_ff;
  logic ovf_prev_ff;

  logic access;
  logic wr_en;
  logic wr_ctrl;
  logic wr_stat;
  logic cycle_done;
  logic counted_mode;
  logic target_hit;
  logic nxt_test;
  logic [STAT_W-1:0] stat_set;
  logic [STAT_W-1:0] stat_clr;
  logic [31:0] nxt_prdata;
  logic nxt_slverr;

  // apb: one wait state so read data comes from a flop
  assign access = psel && penable;
  assign wr_en = access && pwrite && pready_ff;
  assign wr_ctrl = wr_en && (paddr == OFS_CTRL);
  assign wr_stat = wr_en && (paddr == OFS_STAT);

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    case (paddr)
      OFS_CTRL:
      begin
        nxt_prdata[CTRL_MODE_LSB +: 3] = mode_ff;
        nxt_prdata[CTRL_DOUBLE_SAMPLE_ENABLE_BIT] = double_sample_enable_ff;
        nxt_prdata[CTRL_SHIFT_LSB +: SH_W] = shift_ff;
        nxt_prdata[CTRL_CLR_BIT] = clr_ff;
      end
      OFS_RPT:
      begin
        nxt_prdata[CNT_W-1:0] = rpt_ff;
      end
      OFS_ACC:
      begin
        nxt_prdata[ACC_W-1:0] = acc_if.acc;
      end
      OFS_CNT:
      begin
        nxt_prdata[CNT_W-1:0] = acc_if.cnt;
      end
      OFS_FLTR:
      begin
        nxt_prdata[ACC_W-1:0] = acc_if.fltr;
      end
      OFS_STAT:
      begin
        nxt_prdata[STAT_W-1:0] = stat_ff;
      end
      OFS_MASK:
      begin
        nxt_prdata[STAT_W-1:0] = mask_ff;
      end
      default:
      begin
        nxt_slverr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= access && !pready_ff;
      pslverr_ff <= access && !pready_ff && nxt_slverr;
      if (access && !pready_ff && !pwrite)
      begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // control register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode_ff <= MODE_BASIC;
      double_sample_enable_ff <= RST_DOUBLE_SAMPLE_ENABLE;
      shift_ff <= RST_SHIFT;
    end
    else if (wr_ctrl)
    begin
      case (pwdata[CTRL_MODE_LSB +: 3])
        MODE_ACCUM: mode_ff <= MODE_ACCUM;
        MODE_AVG: mode_ff <= MODE_AVG;
        MODE_BURST: mode_ff <= MODE_BURST;
        MODE_LPF: mode_ff <= MODE_LPF;
        default: mode_ff <= MODE_BASIC;
      endcase
      double_sample_enable_ff <= pwdata[CTRL_DOUBLE_SAMPLE_ENABLE_BIT];
      shift_ff <= pwdata[CTRL_SHIFT_LSB +: SH_W];
    end
  end

  // clear request: software sets, hardware drops when done
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clr_ff <= 1'b0;
    end
    else if (wr_ctrl && pwdata[CTRL_CLR_BIT])
    begin
      clr_ff <= 1'b1;
    end
    else if (acc_if.clr_done)
    begin
      clr_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rpt_ff <= RST_RPT;
      mask_ff <= RST_MASK;
    end
    else if (wr_en && paddr == OFS_RPT)
    begin
      rpt_ff <= pwdata[CNT_W-1:0];
    end
    else if (wr_en && paddr == OFS_MASK)
    begin
      mask_ff <= pwdata[STAT_W-1:0];
    end
  end

  // double sampling: hold first sample, complete the cycle on the second
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phase_ff <= 1'b0;
      first_ff <= '0;
    end
    else if (!double_sample_enable_ff)
    begin
      phase_ff <= 1'b0;
    end
    else if (conv_done)
    begin
      phase_ff <= !phase_ff;
      if (!phase_ff)
      begin
        first_ff <= conv_data;
      end
    end
  end

  assign cycle_done = conv_done && (!double_sample_enable_ff || phase_ff);
  assign counted_mode = (mode_ff != MODE_BASIC);

  assign acc_if.mode = mode_ff;
  assign acc_if.shift = shift_ff;
  assign acc_if.clr_req = clr_ff;
  assign acc_if.smp_vld = cycle_done && counted_mode;
  assign acc_if.contrib = double_sample_enable_ff
    ? $signed({1'b0, conv_data}) - $signed({1'b0, first_ff})
    : $signed({1'b0, conv_data});
  assign acc_if.trig_clr = conv_trig &&
    ((mode_ff == MODE_AVG && acc_if.cnt >= rpt_ff) || mode_ff == MODE_BURST);

  arc_accum u_accum (
    .clk(clk),
    .reset(reset),
    .a(acc_if.acu)
  );

  // threshold test decision
  assign target_hit = (acc_if.cnt >= rpt_ff);

  always_comb
  begin
    nxt_test = 1'b0;
    if (acc_if.upd)
    begin
      case (mode_ff)
        MODE_ACCUM: nxt_test = 1'b1;
        MODE_AVG: nxt_test = target_hit;
        MODE_BURST: nxt_test = target_hit;
        MODE_LPF: nxt_test = target_hit;
        default: nxt_test = 1'b0;
      endcase
    end
    if (basic_ff)
    begin
      nxt_test = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      basic_ff <= 1'b0;
      test_ff <= 1'b0;
      retrig_ff <= 1'b0;
    end
    else
    begin
      basic_ff <= cycle_done && !counted_mode;
      test_ff <= nxt_test;
      retrig_ff <= acc_if.upd && mode_ff == MODE_BURST && !target_hit;
    end
  end

  // sticky status, write one to clear, set wins over clear
  always_comb
  begin
    stat_set = '0;
    stat_set[STAT_DONE_BIT] = conv_done;
    stat_set[STAT_THR_BIT] = nxt_test;
    stat_set[STAT_OVF_BIT] = acc_if.ovf && !ovf_prev_ff;
    stat_clr = wr_stat ? pwdata[STAT_W-1:0] : '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stat_ff <= RST_STAT;
      ovf_prev_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      stat_ff <= (stat_ff & ~stat_clr) | stat_set;
      ovf_prev_ff <= acc_if.ovf;
      irq_ff <= |(((stat_ff & ~stat_clr) | stat_set) & mask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign retrig = retrig_ff;
  assign test_strobe = test_ff;
  assign irq = irq_ff;
endmodule : arc_top

// *** verif/arc_core_model.sv ***
`timescale 1ns/10ps
module arc_core_model
  import arc_pkg::*;
(
  input wire logic clk,
  input wire logic retrig,
  output logic conv_trig,
  output logic conv_done,
  output logic [RES_W-1:0] conv_data
);
  logic td = 1'b0;
  logic rq = 1'b0;
  logic [RES_W-1:0] dat = 12'h000;
  initial conv_trig = 1'b0;
  // burst repeat answered on the next cycle
  always @(posedge clk) rq <= (retrig === 1'b1);
  assign conv_done = td | rq;
  // idle data shows the inverse of the last result
  assign conv_data = conv_done ? dat : ~dat;
  task smp(input logic [RES_W-1:0] d, input logic t);
    @(posedge clk);
    td <= 1'b1;
    conv_trig <= t;
    dat <= d;
    @(posedge clk);
    td <= 1'b0;
    conv_trig <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : smp
endmodule : arc_core_model

// *** verif/arc_top_sva.sv ***
`timescale 1ns/10ps
module arc_top_sva
  import arc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_trig,
  input wire logic conv_done,
  input wire logic retrig,
  input wire logic test_strobe
);
  logic [2:0] md_ff;
  logic ds_ff;
  logic [7:0] rpt_ff;
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  // shadow of mode and repeat target
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      md_ff <= 3'h0;
      ds_ff <= 1'b0;
      rpt_ff <= 8'h00;
    end
    else if (wr && paddr == OFS_CTRL)
    begin
      md_ff <= (pwdata[2:0] > 3'h4) ? 3'h0 : pwdata[2:0];
      ds_ff <= pwdata[3];
    end
    else if (wr && paddr == OFS_RPT)
      rpt_ff <= pwdata[7:0];
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_smp;
    conv_done && !ds_ff;
  endsequence
  property p_every(logic [2:0] m);
    s_smp ##0 md_ff == m |-> ##2 test_strobe;
  endproperty
  basic_test_a: assert property (p_every(3'h0))
    else $error("no test after basic sample");
  accum_test_a: assert property (p_every(3'h1))
    else $error("no test after accumulate sample");
  burst_rep_a: assert property (conv_trig && conv_done && md_ff == 3'h3
    && !ds_ff && rpt_ff > 8'h01 |-> ##2 retrig && !test_strobe)
    else $error("burst did not retrigger");
  retrig_mode_a: assert property (retrig |-> md_ff == 3'h3 && $past(conv_done, 2))
    else $error("retrigger without burst sample");
  strobe_cause_a: assert property (test_strobe |-> $past(conv_done, 2))
    else $error("test without sample");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  err_pulse_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : arc_top_sva

bind arc_top arc_top_sva arc_top_sva_inst (.clk(clk), .reset(reset), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .conv_trig(conv_trig), .conv_done(conv_done), .retrig(retrig),
  .test_strobe(test_strobe));

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb;
  import arc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, conv_trig, conv_done, retrig, test_strobe, irq, err;
  logic [RES_W-1:0] conv_data;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_str = 0;
  int n_rt = 0;
  always #2 clk = ~clk;
  arc_top arc_top_inst (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_trig(conv_trig), .conv_done(conv_done),
    .conv_data(conv_data), .retrig(retrig), .test_strobe(test_strobe), .irq(irq));
  arc_core_model arc_core_model_inst (.clk(clk), .retrig(retrig),
    .conv_trig(conv_trig), .conv_done(conv_done), .conv_data(conv_data));
  always @(posedge clk)
  begin
    if (test_strobe === 1'b1) n_str++;
    if (retrig === 1'b1) n_rt++;
  end
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      stop_test;
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  task cfg(input logic [2:0] m, input logic [2:0] sh, input logic ds, input logic [7:0] r);
    apb(1'b1, OFS_RPT, {24'h0, r});
    apb(1'b1, OFS_CTRL, {23'h0, 1'b1, 1'b0, sh, ds, m});
    repeat (4) @(posedge clk);
    n_str = 0;
    n_rt = 0;
  endtask : cfg
  task wt(input int n);
    int i;
    for (i = 0; i < 60 && n_str < n; i++) @(posedge clk);
    if (n_str < n)
    begin
      n_mismatch++;
      stop_test;
    end
    repeat (2) @(posedge clk);
  endtask : wt
  task s(input logic [11:0] d, input logic t);
    arc_core_model_inst.smp(d, t);
  endtask : s
  task t_regs;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_ACC, 32'h0);
    rd(OFS_STAT, 32'h0);
    rd(8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h7);
    rd(OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h4);
    rd(OFS_CTRL, 32'h4);
  endtask : t_regs
  task t_accum;
    cfg(3'h1, 3'h2, 1'b0, 8'h00);
    s(12'h064, 1'b1);
    s(12'h0c8, 1'b1);
    s(12'h12c, 1'b1);
    rd(OFS_ACC, 32'h258);
    rd(OFS_CNT, 32'h3);
    rd(OFS_FLTR, 32'h96);
    chk(n_str, 3);
    rd(OFS_STAT, 32'h3);
    cfg(3'h1, 3'h2, 1'b0, 8'h00);
    rd(OFS_ACC, 32'h0);
    rd(OFS_CNT, 32'h0);
    rd(OFS_CTRL, 32'h21);
  endtask : t_accum
  task t_sat;
    cfg(3'h1, 3'h0, 1'b0, 8'h00);
    repeat (256) s(12'hfff, 1'b1);
    rd(OFS_CNT, 32'hff);
    rd(OFS_ACC, 32'h3ff00);
    rd(OFS_STAT, 32'h7);
    apb(1'b1, OFS_MASK, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, OFS_STAT, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
  endtask : t_sat
  task t_avg;
    cfg(3'h2, 3'h0, 1'b0, 8'h02);
    s(12'h00a, 1'b1);
    chk(n_str, 0);
    s(12'h014, 1'b1);
    chk(n_str, 1);
    s(12'h01e, 1'b1);
    rd(OFS_ACC, 32'h1e);
    rd(OFS_CNT, 32'h1);
    chk(n_str, 1);
  endtask : t_avg
  task t_burst;
    cfg(3'h3, 3'h0, 1'b0, 8'h03);
    s(12'h005, 1'b1);
    wt(1);
    chk(n_rt, 2);
    rd(OFS_CNT, 32'h3);
    s(12'h005, 1'b1);
    wt(2);
    chk(n_str, 2);
    rd(OFS_ACC, 32'hf);
  endtask : t_burst
  task t_lpf;
    cfg(3'h4, 3'h1, 1'b0, 8'h02);
    repeat (3) s(12'h064, 1'b1);
    chk(n_str, 2);
    rd(OFS_ACC, 32'haf);
    rd(OFS_FLTR, 32'h57);
  endtask : t_lpf
  task t_pair;
    cfg(3'h1, 3'h0, 1'b1, 8'h00);
    s(12'h032, 1'b1);
    s(12'h050, 1'b1);
    rd(OFS_ACC, 32'h1e);
    chk(n_str, 1);
    apb(1'b1, OFS_CTRL, 32'h0);
    n_str = 0;
    s(12'h007, 1'b1);
    s(12'h009, 1'b1);
    chk(n_str, 2);
    rd(OFS_ACC, 32'h1e);
  endtask : t_pair
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_accum;
    t_sat;
    t_avg;
    t_burst;
    t_lpf;
    t_pair;
    stop_test;
  end
endmodule : tb
